/* shared/vpi_pkg.sv */
// shared constants and types for the vectored priority interrupt block
package vpi_pkg;

    // ----------------------------------------------------------------
    // priority levels
    // ----------------------------------------------------------------
    localparam logic [4:0] LVL_RESET     = 5'h01;
    localparam logic [4:0] LVL_FIRST_MSK = 5'h02;
    localparam logic [4:0] LVL_LAST_MSK  = 5'h10;
    localparam logic [4:0] LVL_BREAK     = 5'h11;
    localparam int         LVL_LO        = 2;
    localparam int         LVL_HI        = 16;

    // ----------------------------------------------------------------
    // vector table: low byte of level 1 at the top, two bytes per level
    // ----------------------------------------------------------------
    localparam logic [15:0] VECTOR_TOP_LOW = 16'hFFFC;
    localparam logic [15:0] VECTOR_STEP    = 16'h0002;
    localparam logic [15:0] VECTOR_HI_BIT  = 16'h0001;

    // ----------------------------------------------------------------
    // source selection bits (0 picks the first source of the pair)
    // ----------------------------------------------------------------
    localparam int SEL_INT0_TZ     = 0;
    localparam int SEL_SIO1TX_TW   = 1;
    localparam int SEL_COUNTER_PIN_ZERO_TW    = 2;
    localparam int SEL_COUNTER_PIN_ONE_SIO3R = 3;
    localparam int SEL_SIO2_TZ     = 4;
    localparam int SEL_EXT_IRQ_TWO_XFER   = 5;
    localparam int SEL_EXT_IRQ_FOUR_COUNTER_PIN_TWO  = 6;
    localparam int SEL_ADC_SIO3T   = 7;

    // ----------------------------------------------------------------
    // edge pins, index into pin and edge select vectors
    // ----------------------------------------------------------------
    localparam int PIN_INT0  = 0;
    localparam int PIN_EXT_IRQ_ONE  = 1;
    localparam int PIN_EXT_IRQ_TWO  = 2;
    localparam int PIN_EXT_IRQ_THREE  = 3;
    localparam int PIN_EXT_IRQ_FOUR  = 4;
    localparam int PIN_COUNTER_PIN_ZERO = 5;
    localparam int PIN_COUNTER_PIN_ONE = 6;
    localparam int PIN_COUNTER_PIN_TWO = 7;
    localparam int PIN_TWCLK = 8;
    localparam int PIN_TWDAT = 9;
    localparam int NUM_PINS  = 10;

    // serial port selection bits
    localparam int SIO_ONE   = 0;
    localparam int SIO_TWO   = 1;
    localparam int SIO_THREE = 2;

    // ----------------------------------------------------------------
    // on-chip event pulses from peripherals
    // ----------------------------------------------------------------
    typedef struct packed {
        logic timer_z;
        logic timer_x;
        logic timer_y;
        logic timer_one;
        logic timer_two;
        logic sio1_rx;
        logic sio1_tx;
        logic sio2_done;
        logic sio3_rx;
        logic sio3_tx;
        logic adc_done;
        logic twowire_done;
    } periph_events_s;

    // vector fetch states
    typedef enum logic [2:0] {
        ST_IDLE    = 3'b000,
        ST_PUSH    = 3'b001,
        ST_READ_LO = 3'b010,
        ST_READ_HI = 3'b011,
        ST_FINISH  = 3'b100
    } fetch_state_e;

    // low vector address of a level
    function automatic logic [15:0] vector_low(input logic [4:0] level);
        logic [15:0] ofs;
        ofs = {11'h000, level - 5'h01} * VECTOR_STEP;
        return VECTOR_TOP_LOW - ofs;
    endfunction

endpackage

/* src/vectored_priority_interrupt.sv */
// vectored fixed-priority interrupt controller with vector fetch sequencer
// Function
// - reset is non-maskable level 1, vectors FFFD/FFFC
// - high byte from odd, low from even vector
// - level 2 serves ext irq zero or timer Z
// - level 3 serves ext irq one edge
// - level 4 serves serial one receive done
// - level 5 serves serial one transmit done
// - two-wire line edges share level 5 or 10
// - level 6 serves timer X underflow
// - level 7 serves timer Y underflow
// - level 8 timer one, also ends stop wait
// - level 9 serves timer two underflow
// - level 10 serves counter pin zero edge
// - level 11 counter pin one or serial three rx
// - level 12 serial two or timer Z
// - level 13 ext irq two or two-wire transfer
// - level 14 serves ext irq three edge
// - level 15 ext irq four or counter pin two
// - level 16 converter done or serial three tx
// - software break is non-maskable lowest level 17
// - serial sources request only while port selected
// - taken when request, enable set, disable clear
// - accept pushes state (not for reset), sets disable, clears request
// - selection bits choose source of shared levels
`timescale 1ns/10ps
`default_nettype none

module vectored_priority_interrupt #(
    parameter int SYNC_STAGES = 3
) (
    input  wire logic                     clock,
    input  wire logic                     sys_rst,
    input  wire logic [9:0]               edge_pins,
    input  wire logic [9:0]               edge_falling,
    input  wire vpi_pkg::periph_events_s  events,
    input  wire logic [7:0]               source_select,
    input  wire logic                     twowire_variant,
    input  wire logic [2:0]               sio_selected,
    input  wire logic [16:2]              irq_enable,
    input  wire logic [16:2]              request_clear,
    input  wire logic                     interrupt_disable,
    input  wire logic                     software_break_instr,
    input  wire logic                     stop_mode_instr,
    input  wire logic [7:0]               mem_data,
    output logic                          mem_read,
    output logic [15:0]                   mem_addr,
    output logic                          stack_push,
    output logic                          disable_set,
    output logic                          pc_load,
    output logic [15:0]                   pc_value,
    output logic [4:0]                    active_level,
    output logic                          busy,
    output logic [16:2]                   request_state,
    output logic                          stop_release
);

    // ----------------------------------------------------------------
    // elaboration checks
    // ----------------------------------------------------------------
    if (SYNC_STAGES != 3) begin : g_bad_sync
        $error("SYNC_STAGES must be 3");
    end

    // ----------------------------------------------------------------
    // pin synchronisers and edge detectors
    // ----------------------------------------------------------------
    logic [9:0] pin_s1;
    logic [9:0] pin_s2;
    logic [9:0] pin_s3;
    logic [9:0] pin_level;
    logic [9:0] pin_edge;

    // three-stage capture of asynchronous pins
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            pin_s1 <= 10'h000;
            pin_s2 <= 10'h000;
            pin_s3 <= 10'h000;
        end else begin
            pin_s1 <= edge_pins;
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
        end
    end

    // accepted level follows only when stages two and three agree
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            pin_level <= 10'h000;
        end else begin
            pin_level <= (pin_s2 & pin_s3) | (pin_level & (pin_s2 | pin_s3));
        end
    end

    logic [3:0] sync_fill;

    // edges ignored until stages and accepted level hold real pin values
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            sync_fill <= 4'h0;
        end else begin
            sync_fill <= {sync_fill[2:0], 1'b1};
        end
    end

    // rising or falling edge per pin, as selected
    genvar gi;
    for (gi = 0; gi < vpi_pkg::NUM_PINS; gi++) begin : g_edge
        logic next_level;
        assign next_level = (pin_s2[gi] & pin_s3[gi]) | (pin_level[gi] & (pin_s2[gi] | pin_s3[gi]));
        assign pin_edge[gi] = sync_fill[3] & (edge_falling[gi] ? (pin_level[gi] & ~next_level)
                                                               : (~pin_level[gi] & next_level));
    end

    // ----------------------------------------------------------------
    // per-level request sources
    // ----------------------------------------------------------------
    logic [16:2] raise;
    logic        tw_edge;
    logic        sio1_ok;
    logic        sio2_ok;
    logic        sio3_ok;

    assign tw_edge = twowire_variant
                   & (pin_edge[vpi_pkg::PIN_TWCLK] | pin_edge[vpi_pkg::PIN_TWDAT]);
    assign sio1_ok = sio_selected[vpi_pkg::SIO_ONE];
    assign sio2_ok = sio_selected[vpi_pkg::SIO_TWO];
    assign sio3_ok = sio_selected[vpi_pkg::SIO_THREE];

    // shared levels muxed by the selection bits
    always_comb begin
        raise = '0;
        raise[2]  = source_select[vpi_pkg::SEL_INT0_TZ] ? events.timer_z
                  : pin_edge[vpi_pkg::PIN_INT0];
        raise[3]  = pin_edge[vpi_pkg::PIN_EXT_IRQ_ONE];
        raise[4]  = events.sio1_rx & sio1_ok;
        raise[5]  = (source_select[vpi_pkg::SEL_SIO1TX_TW] && twowire_variant) ? tw_edge
                  : (events.sio1_tx & sio1_ok);
        raise[6]  = events.timer_x;
        raise[7]  = events.timer_y;
        raise[8]  = events.timer_one;
        raise[9]  = events.timer_two;
        raise[10] = (source_select[vpi_pkg::SEL_COUNTER_PIN_ZERO_TW] && twowire_variant) ? tw_edge
                  : pin_edge[vpi_pkg::PIN_COUNTER_PIN_ZERO];
        raise[11] = source_select[vpi_pkg::SEL_COUNTER_PIN_ONE_SIO3R] ? (events.sio3_rx & sio3_ok)
                  : pin_edge[vpi_pkg::PIN_COUNTER_PIN_ONE];
        raise[12] = source_select[vpi_pkg::SEL_SIO2_TZ] ? events.timer_z
                  : (events.sio2_done & sio2_ok);
        raise[13] = (source_select[vpi_pkg::SEL_EXT_IRQ_TWO_XFER] && twowire_variant)
                  ? events.twowire_done : pin_edge[vpi_pkg::PIN_EXT_IRQ_TWO];
        raise[14] = pin_edge[vpi_pkg::PIN_EXT_IRQ_THREE];
        raise[15] = source_select[vpi_pkg::SEL_EXT_IRQ_FOUR_COUNTER_PIN_TWO] ? pin_edge[vpi_pkg::PIN_COUNTER_PIN_TWO]
                  : pin_edge[vpi_pkg::PIN_EXT_IRQ_FOUR];
        raise[16] = source_select[vpi_pkg::SEL_ADC_SIO3T] ? (events.sio3_tx & sio3_ok)
                  : events.adc_done;
    end

    // ----------------------------------------------------------------
    // priority resolution
    // ----------------------------------------------------------------
    vpi_pkg::fetch_state_e state;
    logic                  reset_pend;
    logic                  break_pend;
    logic                  win;
    logic [4:0]            win_lvl;
    logic                  accept;
    logic [16:2]           accept_clr;

    // smallest enabled level wins; reset above all, break below all
    always_comb begin
        win     = 1'b0;
        win_lvl = 5'h00;
        if (reset_pend) begin
            win     = 1'b1;
            win_lvl = vpi_pkg::LVL_RESET;
        end else begin
            for (int i = vpi_pkg::LVL_HI; i >= vpi_pkg::LVL_LO; i--) begin
                if (request_state[i] && irq_enable[i] && !interrupt_disable) begin
                    win     = 1'b1;
                    win_lvl = 5'(i);
                end
            end
            if (!win && break_pend) begin
                win     = 1'b1;
                win_lvl = vpi_pkg::LVL_BREAK;
            end
        end
    end

    assign accept = win && (state == vpi_pkg::ST_IDLE);

    // one-hot clear of the accepted maskable request
    always_comb begin
        accept_clr = '0;
        for (int i = vpi_pkg::LVL_LO; i <= vpi_pkg::LVL_HI; i++) begin
            accept_clr[i] = accept && (win_lvl == 5'(i));
        end
    end

    // ----------------------------------------------------------------
    // request bits: a new event wins over any clear
    // ----------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            request_state <= '0;
        end else begin
            request_state <= (request_state & ~request_clear & ~accept_clr) | raise;
        end
    end

    // non-maskable pendings: reset raised by reset, break by instruction
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            reset_pend <= 1'b1;
            break_pend <= 1'b0;
        end else begin
            if (accept && win_lvl == vpi_pkg::LVL_RESET) begin
                reset_pend <= 1'b0;
            end
            if (software_break_instr) begin
                break_pend <= 1'b1;
            end else if (accept && win_lvl == vpi_pkg::LVL_BREAK) begin
                break_pend <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // acceptance and vector fetch sequencer
    // ----------------------------------------------------------------
    logic [15:0] vec_lo;
    logic [7:0]  lo_byte;

    assign vec_lo = vpi_pkg::vector_low(active_level);

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            state        <= vpi_pkg::ST_IDLE;
            active_level <= 5'h00;
            busy         <= 1'b0;
            stack_push   <= 1'b0;
            disable_set  <= 1'b0;
            mem_read     <= 1'b0;
            mem_addr     <= 16'h0000;
            lo_byte      <= 8'h00;
            pc_load      <= 1'b0;
            pc_value     <= 16'h0000;
        end else begin
            stack_push  <= 1'b0;
            disable_set <= 1'b0;
            pc_load     <= 1'b0;
            unique case (state)
                vpi_pkg::ST_IDLE: begin
                    if (accept) begin
                        active_level <= win_lvl;
                        busy         <= 1'b1;
                        stack_push   <= (win_lvl != vpi_pkg::LVL_RESET);
                        disable_set  <= 1'b1;
                        state        <= vpi_pkg::ST_PUSH;
                    end
                end
                vpi_pkg::ST_PUSH: begin
                    mem_read <= 1'b1;
                    mem_addr <= vec_lo;
                    state    <= vpi_pkg::ST_READ_LO;
                end
                vpi_pkg::ST_READ_LO: begin
                    mem_addr <= vec_lo | vpi_pkg::VECTOR_HI_BIT;
                    state    <= vpi_pkg::ST_READ_HI;
                end
                vpi_pkg::ST_READ_HI: begin
                    lo_byte  <= mem_data;
                    mem_read <= 1'b0;
                    state    <= vpi_pkg::ST_FINISH;
                end
                vpi_pkg::ST_FINISH: begin
                    pc_value <= {mem_data, lo_byte};
                    pc_load  <= 1'b1;
                    busy     <= 1'b0;
                    state    <= vpi_pkg::ST_IDLE;
                end
                default: begin
                    state <= vpi_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // stop-mode release wait ended by timer one underflow
    // ----------------------------------------------------------------
    logic stop_wait;

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            stop_wait    <= 1'b0;
            stop_release <= 1'b0;
        end else begin
            stop_release <= stop_wait && events.timer_one;
            if (stop_mode_instr) begin
                stop_wait <= 1'b1;
            end else if (events.timer_one) begin
                stop_wait <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    a_reset_first_vec: assert property ($fell(sys_rst) |->
        ##2 (mem_addr == vpi_pkg::VECTOR_TOP_LOW)
        ##1 (mem_addr == (vpi_pkg::VECTOR_TOP_LOW | vpi_pkg::VECTOR_HI_BIT)))
        else $error("reset vector fetch wrong");
    a_fetch_pair_order: assert property ($rose(mem_read) |-> !mem_addr[0] ##1
        (mem_addr == ($past(mem_addr) | vpi_pkg::VECTOR_HI_BIT)) && mem_addr[0])
        else $error("high byte not fetched from odd address");
    a_pc_assembly: assert property (state == vpi_pkg::ST_FINISH |=>
        pc_load && pc_value == {$past(mem_data), $past(lo_byte)})
        else $error("pc value not assembled");
    a_level_two_sel: assert property (!source_select[0] && events.timer_z
        && !pin_edge[0] && !request_state[2] |=> !request_state[2])
        else $error("timer z raised level two while deselected");
    a_sio_gate_rx: assert property (!sio_selected[0] && events.sio1_rx
        && !request_state[4] |=> !request_state[4])
        else $error("serial one request while port not selected");
    a_stop_release: assert property (stop_wait && events.timer_one && !stop_mode_instr
        |=> stop_release && !stop_wait)
        else $error("stop wait not released by timer one");
    a_masked_not_taken: assert property (accept && win_lvl >= vpi_pkg::LVL_FIRST_MSK
        && win_lvl <= vpi_pkg::LVL_LAST_MSK |-> !interrupt_disable && irq_enable[win_lvl])
        else $error("masked level accepted");
    a_accept_clears: assert property (accept && win_lvl == 5'h06 && !raise[6]
        |=> !request_state[6] && disable_set && stack_push)
        else $error("accept did not clear request or push");
    a_set_beats_clr: assert property (raise[9] && request_clear[9]
        |=> request_state[9])
        else $error("clear won over new event");
    a_break_lowest: assert property (accept && win_lvl == vpi_pkg::LVL_BREAK
        |-> !reset_pend && (interrupt_disable || !(|(request_state & irq_enable))))
        else $error("break taken over pending maskable");
    a_fetch_done_time: assert property (accept |-> ##5 pc_load)
        else $error("vector fetch took wrong number of cycles");

    c_reset_fetch: cover property (pc_load && pc_value != 16'h0000 && active_level == 5'h01);
    c_two_pending: cover property (accept && $countones(request_state & irq_enable) >= 2);
    c_break_taken: cover property (accept && win_lvl == 5'h11);
    c_twowire_lvl5: cover property (twowire_variant && tw_edge && source_select[1]);

endmodule // vectored_priority_interrupt

`default_nettype wire

/* tb/vector_rom_model.sv */
// vector memory model answering the vector fetches of the interrupt block
`timescale 1ns/10ps
`default_nettype none

module vector_rom_model (
    input  wire logic        clock,
    input  wire logic        sys_rst,
    input  wire logic        mem_read,
    input  wire logic [15:0] mem_addr,
    output var  logic [7:0]  mem_data
);
    // byte the cycle after the address, a toggling pattern when not read
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            mem_data <= 8'hA5;
        end else if (mem_read) begin
            mem_data <= mem_addr[7:0] ^ 8'h5A;
        end else begin
            mem_data <= ~mem_data;
        end
    end
endmodule // vector_rom_model
`default_nettype wire

/* tb/tb.sv */
// self-checking testbench for the vectored priority interrupt block
`timescale 1ns/10ps
`default_nettype none

module tb;
    logic                    clock;
    logic                    sys_rst;
    logic [9:0]              edge_pins;
    logic [9:0]              edge_falling;
    vpi_pkg::periph_events_s events;
    logic [7:0]              source_select;
    logic                    twowire_variant;
    logic [2:0]              sio_selected;
    logic [16:2]             irq_enable;
    logic [16:2]             request_clear;
    logic                    interrupt_disable;
    logic                    software_break_instr;
    logic                    stop_mode_instr;
    logic [7:0]              mem_data;
    logic                    mem_read;
    logic [15:0]             mem_addr;
    logic                    stack_push;
    logic                    disable_set;
    logic                    pc_load;
    logic [15:0]             pc_value;
    logic [4:0]              active_level;
    logic                    busy;
    logic [16:2]             request_state;
    logic                    stop_release;
    int                      fail_count;
    int                      check_count;
    int                      cycles;
    // source (event bit, or 12 + pin), selection, expected level
    int tab [23][3] = '{'{11, 1, 2}, '{11, 16, 12}, '{12, 0, 2},
        '{13, 0, 3}, '{6, 0, 4}, '{5, 0, 5}, '{20, 2, 5},
        '{21, 4, 10}, '{0, 32, 13}, '{10, 0, 6}, '{9, 0, 7},
        '{8, 0, 8}, '{7, 0, 9}, '{17, 0, 10}, '{18, 0, 11},
        '{3, 8, 11}, '{4, 0, 12}, '{14, 0, 13}, '{15, 0, 14},
        '{16, 0, 15}, '{19, 64, 15}, '{1, 0, 16}, '{2, 128, 16}};

    vector_rom_model partner (.clock, .sys_rst, .mem_read, .mem_addr, .mem_data);

    vectored_priority_interrupt #(.SYNC_STAGES(3)) dut (
        .clock, .sys_rst, .edge_pins, .edge_falling, .events, .source_select,
        .twowire_variant, .sio_selected, .irq_enable, .request_clear,
        .interrupt_disable, .software_break_instr, .stop_mode_instr, .mem_data,
        .mem_read, .mem_addr, .stack_push, .disable_set, .pc_load, .pc_value,
        .active_level, .busy, .request_state, .stop_release
    );

    // --------------------------------------------------------------
    // shared helpers
    // --------------------------------------------------------------
    function automatic logic [7:0] vb(input logic [15:0] a);
        return a[7:0] ^ 8'h5A;
    endfunction

    task automatic check(input logic ok, input string msg);
        check_count++;
        if (ok !== 1'b1) begin
            fail_count++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask

    task automatic print_verdict();
        if (fail_count == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // waits for the jump and judges level, vector and state push
    task automatic expect_fetch(input logic [4:0] lvl, input logic push);
        logic [15:0] lo;
        logic        saw;
        saw = 1'b0;
        lo = 16'hFFFC - {10'h000, lvl - 5'h01, 1'b0};
        #1;
        for (int i = 0; i < 60 && pc_load !== 1'b1; i++) begin
            if (stack_push === 1'b1 && disable_set === 1'b1) saw = 1'b1;
            @(posedge clock);
            #1;
        end
        check(pc_load === 1'b1 && active_level === lvl, "wrong level served");
        check(pc_value === {vb(lo | 16'h0001), vb(lo)}, "wrong vector");
        check(saw === push, "state push missing");
        @(posedge clock);
    endtask

    // --------------------------------------------------------------
    // scenarios
    // --------------------------------------------------------------
    task automatic fire(input int src, input int sel, input int lvl);
        @(posedge clock);
        irq_enable <= '0;
        source_select <= 8'(sel);
        edge_pins <= 10'h2AA;
        repeat (8) @(posedge clock);
        request_clear <= '1;
        @(posedge clock);
        request_clear <= '0;
        irq_enable <= '1;
        if (src < 12) events <= vpi_pkg::periph_events_s'(12'h001 << src);
        else edge_pins <= 10'h2AA ^ (10'h001 << (src - 12));
        @(posedge clock);
        events <= '0;
        expect_fetch(5'(lvl), 1'b1);
        check(request_state[lvl] === 1'b0, "request not cleared");
    endtask

    task automatic mask_and_order();
        @(posedge clock);
        interrupt_disable <= 1'b1;
        request_clear <= '1;
        events <= vpi_pkg::periph_events_s'(12'h480);
        @(posedge clock);
        request_clear <= '0;
        events <= '0;
        repeat (10) @(posedge clock);
        #1;
        check(busy === 1'b0 && request_state[6] === 1'b1 && request_state[9] === 1'b1,
              "taken while disabled");
        @(posedge clock);
        interrupt_disable <= 1'b0;
        expect_fetch(5'h06, 1'b1);
        expect_fetch(5'h09, 1'b1);
    endtask

    task automatic break_and_stop();
        @(posedge clock);
        interrupt_disable <= 1'b1;
        software_break_instr <= 1'b1;
        @(posedge clock);
        software_break_instr <= 1'b0;
        expect_fetch(5'h11, 1'b1);
        stop_mode_instr <= 1'b1;
        @(posedge clock);
        stop_mode_instr <= 1'b0;
        events <= vpi_pkg::periph_events_s'(12'h100);
        @(posedge clock);
        events <= '0;
        #1;
        check(stop_release === 1'b1, "stop wait not ended");
    endtask

    task automatic serial_gate();
        @(posedge clock);
        sio_selected <= 3'h0;
        twowire_variant <= 1'b0;
        source_select <= 8'h20;
        request_clear <= '1;
        @(posedge clock);
        request_clear <= '0;
        interrupt_disable <= 1'b0;
        events <= vpi_pkg::periph_events_s'(12'h071);
        @(posedge clock);
        events <= '0;
        repeat (6) @(posedge clock);
        #1;
        check(request_state[4] === 1'b0 && request_state[5] === 1'b0
              && request_state[12] === 1'b0 && busy === 1'b0, "serial not gated");
        check(request_state[13] === 1'b0, "two-wire source without variant");
    endtask

    // --------------------------------------------------------------
    // clock, watchdog and main sequence
    // --------------------------------------------------------------
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    always @(posedge clock) begin
        cycles++;
        if (cycles == 5000) begin
            check(1'b0, "timeout");
            print_verdict();
        end
    end

    initial begin
        sys_rst = 1'b1;
        edge_pins = 10'h2AA;
        edge_falling = 10'h2AA;
        events = '0;
        source_select = 8'h00;
        twowire_variant = 1'b1;
        sio_selected = 3'h7;
        irq_enable = '0;
        request_clear = '0;
        interrupt_disable = 1'b0;
        software_break_instr = 1'b0;
        stop_mode_instr = 1'b0;
        repeat (8) @(posedge clock);
        sys_rst <= 1'b0;
        expect_fetch(5'h01, 1'b0);
        foreach (tab[i]) fire(tab[i][0], tab[i][1], tab[i][2]);
        mask_and_order();
        break_and_stop();
        serial_gate();
        print_verdict();
    end
endmodule // tb
`default_nettype wire
